// ===== rtl/ucn_pkg.sv
// shared constants and types for the user clocking network helpers
`default_nettype none
package ucn_pkg;
   // helper index: transmit and receive
   localparam int unsigned NUM_DIR = 2;
   localparam int unsigned DIR_TX  = 0;
   localparam int unsigned DIR_RX  = 1;

   // width of the edge counters inside each divider
   localparam int unsigned CNT_W = 8;

   // flops in the helper reset release chain
   localparam int unsigned RST_STAGES = 3;

   // second-user-clock rising edges counted before active rises
   localparam logic [CNT_W-1:0] SETTLE_EDGES = 8'h03;

   // values after reset
   localparam logic [CNT_W-1:0] CNT_RST  = 8'h00;
   localparam logic             CLK_RST  = 1'b0;
   localparam logic             ACT_RST  = 1'b0;

   // divide ratios when nothing else is configured (1 = pass through)
   localparam int unsigned DIV_DEFAULT = 1;

   typedef enum logic [1:0] {
      ST_HOLD,
      ST_SETTLE,
      ST_RUN
   } ucn_state_t;
endpackage : ucn_pkg
`default_nettype wire

// ===== rtl/ucn_rst_sync.sv
// reset release chain: asserts at once, releases after a few clocks
`timescale 1ns/1ns
`default_nettype none
module ucn_rst_sync #(
   parameter int unsigned STAGES = ucn_pkg::RST_STAGES
) (
   // clock and chip reset
   input  wire logic clk,
   input  wire logic arst_n,
   // helper reset, asynchronous, active high
   input  wire logic resetIn,
   // high while the helper is held in reset
   output var  logic inReset
);
   import ucn_pkg::*;

   logic              clear_n;
   logic [STAGES-1:0] chain;
   logic [STAGES-1:0] next_chain;

   // either reset seizes the chain without waiting for a clock
   assign clear_n = arst_n & ~resetIn;

   always_comb begin
      next_chain = {chain[STAGES-2:0], 1'b0};
   end

   always_ff @(posedge clk or negedge clear_n) begin
      if (!clear_n) begin
         chain <= '1;
      end else begin
         chain <= next_chain;
      end
   end

   assign inReset = chain[STAGES-1];
endmodule : ucn_rst_sync
`default_nettype wire

// ===== rtl/ucn_clock_network.sv
// transmit and receive user clocking network helpers
`timescale 1ns/1ns
`default_nettype none
module ucn_clock_network #(
   parameter int unsigned TX_USR_DIV  = ucn_pkg::DIV_DEFAULT,
   parameter int unsigned TX_USR2_DIV = ucn_pkg::DIV_DEFAULT,
   parameter int unsigned RX_USR_DIV  = ucn_pkg::DIV_DEFAULT,
   parameter int unsigned RX_USR2_DIV = ucn_pkg::DIV_DEFAULT
) (
   // clock and chip reset
   input  wire logic clk,
   input  wire logic arst_n,
   // transmit helper inputs
   input  wire logic txResetIn,
   input  wire logic txSrcClkIn,
   input  wire logic txResetDoneIn,
   // transmit helper outputs
   output var  logic txSrcClkOut,
   output var  logic txUserClockOut,
   output var  logic txSecondUserClockOut,
   output var  logic txActiveOut,
   output var  logic txResetComplete,
   // receive helper inputs
   input  wire logic rxResetIn,
   input  wire logic rxSrcClkIn,
   input  wire logic rxResetDoneIn,
   // receive helper outputs
   output var  logic rxSrcClkOut,
   output var  logic rxUserClockOut,
   output var  logic rxSecondUserClockOut,
   output var  logic rxActiveOut,
   output var  logic rxResetComplete
);
   import ucn_pkg::*;

   function automatic logic ucnLast(input logic [CNT_W-1:0] c,
                                    input logic [CNT_W-1:0] lim);
      ucnLast = (c == lim - 8'h01);
   endfunction : ucnLast

   function automatic logic [CNT_W-1:0] ucnStep(input logic [CNT_W-1:0] c,
                                                input logic [CNT_W-1:0] lim);
      ucnStep = ucnLast(c, lim) ? CNT_RST : c + 8'h01;
   endfunction : ucnStep

   // per-helper signals, index DIR_TX or DIR_RX
   logic             resetPin   [NUM_DIR];
   logic             srcPin     [NUM_DIR];
   logic             donePin    [NUM_DIR];
   logic             inReset    [NUM_DIR];
   logic             srcMeta    [NUM_DIR];
   logic             srcSync    [NUM_DIR];
   logic             srcPrev    [NUM_DIR];
   logic             srcEdge    [NUM_DIR];
   logic             doneMeta   [NUM_DIR];
   logic             doneSync   [NUM_DIR];
   logic [CNT_W-1:0] usrCnt     [NUM_DIR];
   logic [CNT_W-1:0] usr2Cnt    [NUM_DIR];
   logic             usrClk     [NUM_DIR];
   logic             usr2Clk    [NUM_DIR];
   logic             usr2Rise   [NUM_DIR];
   logic [CNT_W-1:0] settleCnt  [NUM_DIR];
   ucn_state_t       state      [NUM_DIR];
   logic             activeReg  [NUM_DIR];
   logic             active     [NUM_DIR];
   logic             complete   [NUM_DIR];

   assign resetPin[DIR_TX] = txResetIn;
   assign resetPin[DIR_RX] = rxResetIn;
   assign srcPin[DIR_TX]   = txSrcClkIn;
   assign srcPin[DIR_RX]   = rxSrcClkIn;
   assign donePin[DIR_TX]  = txResetDoneIn;
   assign donePin[DIR_RX]  = rxResetDoneIn;

   for (genvar i = 0; i < NUM_DIR; i++) begin : g_helper
      localparam logic [CNT_W-1:0] U_DIV = (i == DIR_TX) ?
         CNT_W'(TX_USR_DIV) : CNT_W'(RX_USR_DIV);
      localparam logic [CNT_W-1:0] U2_DIV = (i == DIR_TX) ?
         CNT_W'(TX_USR_DIV * TX_USR2_DIV) : CNT_W'(RX_USR_DIV * RX_USR2_DIV);

      logic             next_srcMeta;
      logic             next_srcSync;
      logic             next_srcPrev;
      logic             next_doneMeta;
      logic             next_doneSync;
      logic [CNT_W-1:0] next_usrCnt;
      logic [CNT_W-1:0] next_usr2Cnt;
      logic             next_usrClk;
      logic             next_usr2Clk;
      logic [CNT_W-1:0] next_settleCnt;
      ucn_state_t       next_state;
      logic             next_activeReg;

      ucn_rst_sync #(
         .STAGES (RST_STAGES)
      ) u_rst (
         .clk     (clk),
         .arst_n  (arst_n),
         .resetIn (resetPin[i]),
         .inReset (inReset[i])
      );

      // pin synchronisers and source edge detection
      always_comb begin
         next_srcMeta  = srcPin[i];
         next_srcSync  = srcMeta[i];
         next_srcPrev  = srcSync[i];
         next_doneMeta = donePin[i];
         next_doneSync = doneMeta[i];
      end

      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            srcMeta[i]  <= CLK_RST;
            srcSync[i]  <= CLK_RST;
            srcPrev[i]  <= CLK_RST;
            doneMeta[i] <= 1'b0;
            doneSync[i] <= 1'b0;
         end else begin
            srcMeta[i]  <= next_srcMeta;
            srcSync[i]  <= next_srcSync;
            srcPrev[i]  <= next_srcPrev;
            doneMeta[i] <= next_doneMeta;
            doneSync[i] <= next_doneSync;
         end
      end

      assign srcEdge[i] = srcSync[i] ^ srcPrev[i];

      // both user clocks count edges of the one source; stopped in reset
      always_comb begin
         next_usrCnt  = usrCnt[i];
         next_usr2Cnt = usr2Cnt[i];
         next_usrClk  = usrClk[i];
         next_usr2Clk = usr2Clk[i];
         if (inReset[i]) begin
            next_usrCnt  = CNT_RST;
            next_usr2Cnt = CNT_RST;
            next_usrClk  = CLK_RST;
            next_usr2Clk = CLK_RST;
         end else if (srcEdge[i]) begin
            next_usrCnt  = ucnStep(usrCnt[i], U_DIV);
            next_usr2Cnt = ucnStep(usr2Cnt[i], U2_DIV);
            if (ucnLast(usrCnt[i], U_DIV)) begin
               next_usrClk = ~usrClk[i];
            end
            if (ucnLast(usr2Cnt[i], U2_DIV)) begin
               next_usr2Clk = ~usr2Clk[i];
            end
         end
      end

      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            usrCnt[i]  <= CNT_RST;
            usr2Cnt[i] <= CNT_RST;
            usrClk[i]  <= CLK_RST;
            usr2Clk[i] <= CLK_RST;
         end else begin
            usrCnt[i]  <= next_usrCnt;
            usr2Cnt[i] <= next_usr2Cnt;
            usrClk[i]  <= next_usrClk;
            usr2Clk[i] <= next_usr2Clk;
         end
      end

      assign usr2Rise[i] = next_usr2Clk & ~usr2Clk[i];

      // active qualification paced by the second user clock
      always_comb begin
         next_state     = state[i];
         next_settleCnt = settleCnt[i];
         next_activeReg = activeReg[i];
         case (state[i])
            ST_HOLD, ST_SETTLE: begin
               // a rise in the cycle of release counts as well
               next_state = ST_SETTLE;
               if (usr2Rise[i]) begin
                  next_settleCnt = settleCnt[i] + 8'h01;
                  if (ucnLast(settleCnt[i], SETTLE_EDGES)) begin
                     next_state     = ST_RUN;
                     next_activeReg = 1'b1;
                  end
               end
            end
            ST_RUN: begin
               next_activeReg = 1'b1;
            end
            default: begin
               next_state     = ST_HOLD;
               next_activeReg = ACT_RST;
            end
         endcase
         if (inReset[i]) begin
            next_state     = ST_HOLD;
            next_settleCnt = CNT_RST;
            next_activeReg = ACT_RST;
         end
      end

      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            state[i]     <= ST_HOLD;
            settleCnt[i] <= CNT_RST;
            activeReg[i] <= ACT_RST;
         end else begin
            state[i]     <= next_state;
            settleCnt[i] <= next_settleCnt;
            activeReg[i] <= next_activeReg;
         end
      end

      // reset assertion clears active without waiting for an edge
      assign active[i]   = activeReg[i] & ~inReset[i];
      assign complete[i] = active[i] & doneSync[i];
   end

   assign txSrcClkOut          = srcSync[DIR_TX];
   assign txUserClockOut       = usrClk[DIR_TX];
   assign txSecondUserClockOut = usr2Clk[DIR_TX];
   assign txActiveOut          = active[DIR_TX];
   assign txResetComplete      = complete[DIR_TX];
   assign rxSrcClkOut          = srcSync[DIR_RX];
   assign rxUserClockOut       = usrClk[DIR_RX];
   assign rxSecondUserClockOut = usr2Clk[DIR_RX];
   assign rxActiveOut          = active[DIR_RX];
   assign rxResetComplete      = complete[DIR_RX];

   default clocking cb @(posedge clk); endclocking
   default disable iff (!arst_n);

   sequence s_txUsrDue;
      srcEdge[DIR_TX] && !inReset[DIR_TX]
         && usrCnt[DIR_TX] == CNT_W'(TX_USR_DIV) - 8'h01;
   endsequence

   sequence s_rxUsrDue;
      srcEdge[DIR_RX] && !inReset[DIR_RX]
         && usrCnt[DIR_RX] == CNT_W'(RX_USR_DIV) - 8'h01;
   endsequence

   sequence s_txRelease;
      inReset[DIR_TX] ##1 !inReset[DIR_TX];
   endsequence

   property p_tx_usr_div;
      s_txUsrDue |=> txUserClockOut != $past(txUserClockOut);
   endproperty
   a_tx_usr_div: assert property (p_tx_usr_div)
      else $error("tx user clock missed its toggle");

   property p_tx_usr2_src;
      !$stable(txSecondUserClockOut) && !$past(inReset[DIR_TX])
         |-> $past(srcEdge[DIR_TX]);
   endproperty
   a_tx_usr2_src: assert property (p_tx_usr2_src)
      else $error("tx second user clock moved without source edge");

   property p_rx_usr_div;
      s_rxUsrDue |=> rxUserClockOut != $past(rxUserClockOut);
   endproperty
   a_rx_usr_div: assert property (p_rx_usr_div)
      else $error("rx user clock missed its toggle");

   property p_rx_usr2_src;
      !$stable(rxSecondUserClockOut) && !$past(inReset[DIR_RX])
         |-> $past(srcEdge[DIR_RX]);
   endproperty
   a_rx_usr2_src: assert property (p_rx_usr2_src)
      else $error("rx second user clock moved without source edge");

   property p_active_out_of_reset;
      (txActiveOut |-> !inReset[DIR_TX] && !$past(inReset[DIR_TX]))
         and (rxActiveOut |-> !inReset[DIR_RX] && !$past(inReset[DIR_RX]));
   endproperty
   a_active_out_of_reset: assert property (p_active_out_of_reset)
      else $error("active high while helper in reset");

   property p_tx_src_follow;
      !inReset[DIR_TX] && !$stable(txUserClockOut)
         |-> $past(srcEdge[DIR_TX]);
   endproperty
   a_tx_src_follow: assert property (p_tx_src_follow)
      else $error("tx user clock moved without source edge");

   property p_complete_gated;
      (txResetComplete |-> txActiveOut && $past(txResetDoneIn, 2))
         and (rxResetComplete |-> rxActiveOut && $past(rxResetDoneIn, 2));
   endproperty
   a_complete_gated: assert property (p_complete_gated)
      else $error("reset sequence completed without active clocks");

   property p_tx_active_late;
      s_txRelease |-> !txActiveOut [*2];
   endproperty
   a_tx_active_late: assert property (p_tx_active_late)
      else $error("tx active rose before synchroniser chain");

   property p_active_rise_cause;
      $rose(rxActiveOut) |-> $past(state[DIR_RX] != ST_RUN)
         && $past(usr2Rise[DIR_RX]);
   endproperty
   a_active_rise_cause: assert property (p_active_rise_cause)
      else $error("rx active rose without settle edge");
endmodule : ucn_clock_network
`default_nettype wire

// ===== tb/ucn_xcvr_model.sv
// far-side model: transceiver output clock and reset-done for one helper
`timescale 1ns/1ns
`default_nettype none
module ucn_xcvr_model #(
   parameter int unsigned HALF = 4
) (
   // system clock
   input  wire logic clk,
   // controls from the bench
   input  wire logic run,
   input  wire logic doneReq,
   // toward the helper
   output var  logic srcClk,
   output var  logic resetDone
);
   int unsigned phase;

   initial begin
      srcClk    = 1'h0;
      resetDone = 1'h0;
      phase     = 0;
   end

   // one output clock feeds the helper; stands at 0 while stopped
   always @(negedge clk) begin
      if (!run) begin
         srcClk <= 1'h0;
         phase  <= 0;
      end else if (phase == HALF - 1) begin
         srcClk <= ~srcClk;
         phase  <= 0;
      end else begin
         phase <= phase + 1;
      end
   end

   always @(negedge clk) begin
      resetDone <= doneReq;
   end
endmodule : ucn_xcvr_model
`default_nettype wire

// ===== tb/ucn_clock_network_test.sv
// self-checking bench for the user clocking network helpers
`timescale 1ns/1ns
`default_nettype none
module ucn_clock_network_test;
   import ucn_pkg::*;
   localparam int TXU = 1;
   localparam int TXU2 = 2;
   localparam int RXU = 2;
   localparam int RXU2 = 1;
   localparam int TXHALF = 4;
   localparam int RXHALF = 5;
   localparam int WIN = 240;

   logic       clk;
   logic       arst_n;
   logic       txResetIn;
   logic       rxResetIn;
   logic [1:0] run;
   logic [1:0] doneReq;
   wire  [1:0] srcIn;
   wire  [1:0] doneIn;
   wire  [1:0] src;
   wire  [1:0] usr;
   wire  [1:0] sec;
   wire  [1:0] act;
   wire  [1:0] cmp;
   int         badCount;
   int         totalChecks;

   always #20 clk = ~clk;

   ucn_xcvr_model #(.HALF(TXHALF)) txSide (.clk(clk), .run(run[0]),
      .doneReq(doneReq[0]), .srcClk(srcIn[0]), .resetDone(doneIn[0]));
   ucn_xcvr_model #(.HALF(RXHALF)) rxSide (.clk(clk), .run(run[1]),
      .doneReq(doneReq[1]), .srcClk(srcIn[1]), .resetDone(doneIn[1]));

   ucn_clock_network #(.TX_USR_DIV(TXU), .TX_USR2_DIV(TXU2),
      .RX_USR_DIV(RXU), .RX_USR2_DIV(RXU2)) dut (
      .clk(clk), .arst_n(arst_n),
      .txResetIn(txResetIn), .txSrcClkIn(srcIn[0]),
      .txResetDoneIn(doneIn[0]), .txSrcClkOut(src[0]),
      .txUserClockOut(usr[0]), .txSecondUserClockOut(sec[0]),
      .txActiveOut(act[0]), .txResetComplete(cmp[0]),
      .rxResetIn(rxResetIn), .rxSrcClkIn(srcIn[1]),
      .rxResetDoneIn(doneIn[1]), .rxSrcClkOut(src[1]),
      .rxUserClockOut(usr[1]), .rxSecondUserClockOut(sec[1]),
      .rxActiveOut(act[1]), .rxResetComplete(cmp[1]));

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
      end
   endtask : check

   // latency can shift one toggle in or out of the window
   task automatic check_near(input string what, input int exp, input int got);
      totalChecks++;
      if (got < exp - 1 || got > exp + 1) begin
         badCount++;
         $display("mismatch %s expected %0d seen %0d", what, exp, got);
      end
   endtask : check_near

   // counts second-clock rises from release until active
   task automatic watch_rise(input int d);
      int   rises;
      int   n;
      logic prev;
      rises = 0;
      n = 0;
      prev = sec[d];
      while (act[d] !== 1'h1 && n < 400) begin
         @(negedge clk);
         if (sec[d] === 1'h1 && prev === 1'h0) rises++;
         prev = sec[d];
         n++;
      end
      check("active after release", 8'h01, {7'h00, act[d]});
      check("settle rises", SETTLE_EDGES, 8'(rises));
   endtask : watch_rise

   task automatic t_start();
      repeat (10) @(negedge clk);
      txResetIn = 1'h0;
      rxResetIn = 1'h0;
      fork
         watch_rise(0);
         watch_rise(1);
      join
      $display("test start done");
   endtask : t_start

   task automatic t_divide();
      int s[2];
      int u[2];
      int w[2];
      logic [1:0] ps;
      logic [1:0] pu;
      logic [1:0] pw;
      s = '{0, 0};
      u = '{0, 0};
      w = '{0, 0};
      ps = src;
      pu = usr;
      pw = sec;
      repeat (WIN) begin
         @(negedge clk);
         for (int d = 0; d < 2; d++) begin
            if (src[d] !== ps[d]) s[d]++;
            if (usr[d] !== pu[d]) u[d]++;
            if (sec[d] !== pw[d]) w[d]++;
         end
         ps = src;
         pu = usr;
         pw = sec;
      end
      check_near("tx src toggles", WIN / TXHALF, s[0]);
      check_near("rx src toggles", WIN / RXHALF, s[1]);
      check_near("tx user toggles", WIN / (TXHALF * TXU), u[0]);
      check_near("tx second toggles", WIN / (TXHALF * TXU * TXU2), w[0]);
      check_near("rx user toggles", WIN / (RXHALF * RXU), u[1]);
      check_near("rx second toggles", WIN / (RXHALF * RXU * RXU2), w[1]);
      $display("test divide done");
   endtask : t_divide

   task automatic t_helper_reset();
      rxResetIn = 1'h1;
      run[1] = 1'h0;
      #1;
      check("rx active on reset", 8'h00, {7'h00, act[1]});
      check("tx active kept", 8'h01, {7'h00, act[0]});
      repeat (30) @(negedge clk);
      check("rx clocks held", 8'h00, {6'h00, usr[1], sec[1]});
      check("rx active held", 8'h00, {7'h00, act[1]});
      run[1] = 1'h1;
      repeat (20) @(negedge clk);
      rxResetIn = 1'h0;
      watch_rise(1);
      $display("test helper reset done");
   endtask : t_helper_reset

   task automatic t_complete();
      repeat (10) @(negedge clk);
      check("complete waits done", 8'h00, {6'h00, cmp});
      doneReq = 2'h3;
      repeat (6) @(negedge clk);
      check("complete both", 8'h03, {6'h00, cmp});
      txResetIn = 1'h1;
      #1;
      check("complete drops", 8'h02, {6'h00, cmp});
      @(negedge clk);
      txResetIn = 1'h0;
      watch_rise(0);
      check("complete back", 8'h03, {6'h00, cmp});
      rxResetIn = 1'h1;
      #1;
      check("rx complete gated", 8'h01, {6'h00, cmp});
      @(negedge clk);
      rxResetIn = 1'h0;
      watch_rise(1);
      check("rx complete back", 8'h03, {6'h00, cmp});
      $display("test complete done");
   endtask : t_complete

   task automatic t_chip_reset();
      arst_n = 1'h0;
      @(negedge clk);
      check("outputs in reset", 8'h00,
            {src, usr, sec, act} & 8'hff);
      check("complete in reset", 8'h00, {6'h00, cmp});
      arst_n = 1'h1;
      fork
         watch_rise(0);
         watch_rise(1);
      join
      $display("test chip reset done");
   endtask : t_chip_reset

   task automatic finishTest();
      $display("checks %0d mismatches %0d", totalChecks, badCount);
      if (badCount == 0 && totalChecks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : finishTest

   initial begin
      #(40 * 8000);
      badCount++;
      $display("watchdog expired");
      finishTest();
   end

   initial begin
      clk = 1'h0;
      arst_n = 1'h0;
      txResetIn = 1'h1;
      rxResetIn = 1'h1;
      run = 2'h3;
      doneReq = 2'h0;
      badCount = 0;
      totalChecks = 0;
      repeat (3) @(posedge clk);
      @(negedge clk);
      arst_n = 1'h1;
      t_start();
      t_divide();
      t_helper_reset();
      t_complete();
      t_chip_reset();
      t_divide();
      finishTest();
   end
endmodule : ucn_clock_network_test
`default_nettype wire
